// [design/swire_slave.sv]
// Purpose: Slave end of an open-drain single-wire link with slots, presence and CRC
// Assumes: dq_i is already synchronous to clock_i; mem_rdata_i follows mem_addr_o
// Notes: Scratchpad is kept here; copy is signalled outward, not performed
`timescale 1ns/10ps
module swire_slave
	import swire_pkg::*;
#(
	parameter int STD_RST_CYC = cyc_up(STD_RST_LOW_NS),
	parameter int OD_RST_CYC = cyc_up(OD_RST_LOW_NS),
	parameter int STD_PDH_CYC = cyc_dn(STD_PDH_NS),
	parameter int STD_PDL_CYC = cyc_up(STD_PDL_NS),
	parameter int STD_SLS_CYC = cyc_dn(STD_SLS_NS),
	parameter int STD_SPD_CYC = cyc_up(STD_SPD_NS)
)
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic dq_i,
	output logic dq_o,
	output logic dq_oe_n_o,
	output logic fast_speed_flag_o,
	output logic [15:0] mem_addr_o,
	input wire logic [7:0] mem_rdata_i,
	output logic copy_strobe_o,
	output logic [15:0] copy_addr_o,
	output logic [4:0] copy_end_o,
	input wire logic [4:0] scratch_raddr_i,
	output logic [7:0] scratch_rdata_o
);

	typedef enum logic [2:0] {L_IDLE, L_SLOT, L_RST_RISE, L_PD_HIGH, L_PD_LOW} link_e;
	typedef enum logic [3:0] {P_ROM_CMD, P_ROM_TX, P_MEM_CMD, P_TA1, P_TA2, P_WS_DATA, P_RS_HDR,
		P_RS_DATA, P_RM_DATA, P_CP_ES, P_CRC_TX, P_WAIT} proto_e;
	typedef enum logic [1:0] {K_WS, K_RS, K_CP, K_RM} kind_e;

	link_e link_q, link_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] t_sls, t_spd, t_pdh, t_pdl, t_rst;
	logic drive_q, drive_d, tx_zero_q, tx_zero_d, bit_q, bit_d, fast_q, fast_d;
	logic [2:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] sh_q, sh_d, tx_byte_q, tx_byte_d, next_tx, cur_byte;
	logic byte_done, pres_done, rst_seen, tx_mode;
	proto_e proto_q, proto_d;
	kind_e kind_q, kind_d;
	logic [2:0] idx_q, idx_d;
	logic [4:0] off_q, off_d, end_q, end_d;
	logic [15:0] ta_q, ta_d, addr_q, addr_d, crc;
	logic aa_q, aa_d, pf_q, pf_d, auth_q, auth_d, copy_q, copy_d;
	logic crc_clr, crc_upd, sp_we;
	logic [7:0] es_byte, rd_q;
	logic [7:0] scratch [SP_DEPTH];
	logic [63:0] ident;
	logic [7:0] id_crc;

	crc8_rom u_id_crc (
		.data_i({ID_SERIAL, ID_FAMILY}),
		.crc_o(id_crc)
	);

	crc16_gen u_crc (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.clear_i(crc_clr),
		.upd_i(crc_upd),
		.data_i(sh_q), // Assembled byte, lsb first
		.crc_o(crc)
	);

	// Identity with true CRC in the top byte
	assign ident = {id_crc, ID_SERIAL, ID_FAMILY};
	assign es_byte = {aa_q, 1'b0, pf_q, end_q};
	assign tx_mode = (proto_q == P_ROM_TX) || (proto_q == P_RS_HDR) || (proto_q == P_RS_DATA)
		|| (proto_q == P_RM_DATA) || (proto_q == P_CRC_TX);

	// Timing set follows the speed flag
	always_comb
	begin
		t_sls = fast_q ? CNT_W'(OD_SLS_CYC) : CNT_W'(STD_SLS_CYC);
		t_spd = fast_q ? CNT_W'(OD_SPD_CYC) : CNT_W'(STD_SPD_CYC);
		t_pdh = fast_q ? CNT_W'(OD_PDH_CYC) : CNT_W'(STD_PDH_CYC);
		t_pdl = fast_q ? CNT_W'(OD_PDL_CYC) : CNT_W'(STD_PDL_CYC);
		t_rst = fast_q ? CNT_W'(OD_RST_CYC) : CNT_W'(STD_RST_CYC);
	end

	// Byte to send in the coming slot; memory data is stable long before a slot
	always_comb
	begin
		case (proto_q)
			P_ROM_TX: next_tx = ident[{idx_q, 3'b000} +: 8];
			P_RS_HDR: next_tx = (idx_q == 3'h0) ? ta_q[7:0] : (idx_q == 3'h1) ? ta_q[15:8] : es_byte;
			P_RS_DATA: next_tx = scratch[off_q];
			P_RM_DATA: next_tx = mem_rdata_i;
			P_CRC_TX: next_tx = (idx_q == 3'h0) ? ~crc[7:0] : ~crc[15:8];
			default: next_tx = 8'hff;
		endcase
		cur_byte = (bit_cnt_q == 3'h0) ? next_tx : tx_byte_q;
	end

	// Link timing: slots, reset detection and presence
	always_comb
	begin
		link_d = link_q;
		cnt_d = (cnt_q == {CNT_W{1'b1}}) ? cnt_q : cnt_q + 1'b1;
		drive_d = 1'b0;
		tx_zero_d = tx_zero_q;
		tx_byte_d = tx_byte_q;
		bit_d = bit_q;
		bit_cnt_d = bit_cnt_q;
		sh_d = sh_q;
		fast_d = fast_q;
		byte_done = 1'b0;
		pres_done = 1'b0;
		rst_seen = 1'b0;
		case (link_q)
			L_IDLE:
			begin
				if (!dq_i)
				begin
					link_d = L_SLOT;
					cnt_d = '0;
					tx_byte_d = cur_byte;
					tx_zero_d = tx_mode && !cur_byte[bit_cnt_q];
					drive_d = tx_mode && !cur_byte[bit_cnt_q];
				end
			end
			L_SLOT:
			begin
				drive_d = tx_zero_q && (cnt_d < t_spd);
				if (cnt_q == t_sls)
				begin
					bit_d = dq_i;
					sh_d = {dq_i, sh_q[7:1]};
				end
				if (!drive_q && !dq_i && cnt_q >= t_rst) // Own pull-down excluded, so a read zero cannot be taken for a reset
				begin
					link_d = L_RST_RISE;
					drive_d = 1'b0;
					rst_seen = 1'b1;
					bit_cnt_d = 3'h0;
				end
				else if (dq_i && cnt_q > t_sls && !drive_q)
				begin
					link_d = L_IDLE;
					drive_d = 1'b0;
					bit_cnt_d = bit_cnt_q + 1'b1;
					byte_done = (bit_cnt_q == 3'h7);
				end
			end
			L_RST_RISE:
			begin
				if (dq_i)
				begin
					link_d = L_PD_HIGH;
					cnt_d = '0;
					if (cnt_q >= CNT_W'(STD_RST_CYC))
						fast_d = 1'b0;
				end
			end
			L_PD_HIGH:
			begin
				if (cnt_q == t_pdh)
				begin
					link_d = L_PD_LOW;
					cnt_d = '0;
					drive_d = 1'b1;
				end
			end
			L_PD_LOW:
			begin
				drive_d = 1'b1;
				if (cnt_q == t_pdl)
				begin
					link_d = L_IDLE;
					drive_d = 1'b0;
					pres_done = 1'b1;
				end
			end
			default:
			begin
				link_d = L_IDLE;
			end
		endcase
		if (proto_q == P_ROM_CMD && byte_done && sh_q == CMD_FAST_SKIP)
			fast_d = 1'b1;
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			link_q <= L_IDLE;
			cnt_q <= '0;
			drive_q <= 1'b0;
			tx_zero_q <= 1'b0;
			tx_byte_q <= 8'h00;
			bit_q <= 1'b1;
			bit_cnt_q <= 3'h0;
			sh_q <= 8'h00;
			fast_q <= 1'b0;
		end
		else if (ce_i)
		begin
			link_q <= link_d;
			cnt_q <= cnt_d;
			drive_q <= drive_d;
			tx_zero_q <= tx_zero_d;
			tx_byte_q <= tx_byte_d;
			bit_q <= bit_d;
			bit_cnt_q <= bit_cnt_d;
			sh_q <= sh_d;
			fast_q <= fast_d;
		end
	end

	// Byte-level command sequencing and CRC steering
	always_comb
	begin
		proto_d = proto_q;
		kind_d = kind_q;
		idx_d = idx_q;
		off_d = off_q;
		end_d = end_q;
		ta_d = ta_q;
		addr_d = addr_q;
		aa_d = aa_q;
		pf_d = pf_q;
		auth_d = auth_q;
		copy_d = 1'b0;
		crc_clr = 1'b0;
		crc_upd = 1'b0;
		sp_we = 1'b0;
		if (rst_seen && proto_q == P_WS_DATA && bit_cnt_q != 3'h0)
			pf_d = 1'b1;
		if (pres_done)
			proto_d = P_ROM_CMD;
		else if (byte_done)
		begin
			case (proto_q)
				P_ROM_CMD:
				begin
					idx_d = 3'h0;
					if (sh_q == CMD_SKIP_ID || sh_q == CMD_FAST_SKIP)
						proto_d = P_MEM_CMD;
					else if (sh_q == CMD_READ_ID)
						proto_d = P_ROM_TX;
					else
						proto_d = P_WAIT;
				end
				P_ROM_TX:
				begin
					idx_d = idx_q + 1'b1;
					if (idx_q == ID_LAST_BYTE)
						proto_d = P_MEM_CMD;
				end
				P_MEM_CMD:
				begin
					crc_clr = 1'b1;
					crc_upd = 1'b1;
					idx_d = 3'h0;
					auth_d = 1'b1;
					proto_d = P_TA1;
					case (sh_q)
						CMD_WRITE_SP: kind_d = K_WS;
						CMD_COPY_SP: kind_d = K_CP;
						CMD_READ_MEM_CRC: kind_d = K_RM;
						CMD_READ_SP:
						begin
							kind_d = K_RS;
							proto_d = P_RS_HDR;
						end
						default: proto_d = P_WAIT;
					endcase
				end
				P_TA1:
				begin
					crc_upd = 1'b1;
					proto_d = P_TA2;
					if (kind_q == K_CP)
						auth_d = auth_q && (sh_q == ta_q[7:0]);
					else
						ta_d[7:0] = sh_q;
				end
				P_TA2:
				begin
					crc_upd = 1'b1;
					if (kind_q == K_CP)
					begin
						auth_d = auth_q && (sh_q == ta_q[15:8]);
						proto_d = P_CP_ES;
					end
					else if (kind_q == K_RM)
					begin
						ta_d[15:8] = sh_q;
						addr_d = {sh_q, ta_q[7:0]};
						proto_d = P_RM_DATA;
					end
					else
					begin
						ta_d[15:8] = sh_q;
						off_d = ta_q[4:0];
						aa_d = 1'b0;
						pf_d = 1'b0;
						proto_d = P_WS_DATA;
					end
				end
				P_WS_DATA:
				begin
					crc_upd = 1'b1;
					sp_we = 1'b1;
					end_d = off_q;
					off_d = off_q + 1'b1;
					if (off_q == SP_LAST)
						proto_d = P_CRC_TX;
				end
				P_RS_HDR:
				begin
					crc_upd = 1'b1;
					idx_d = idx_q + 1'b1;
					if (idx_q == HDR_LAST)
					begin
						off_d = ta_q[4:0];
						proto_d = P_RS_DATA;
					end
				end
				P_RS_DATA:
				begin
					crc_upd = 1'b1;
					off_d = off_q + 1'b1;
					idx_d = 3'h0;
					if (off_q == SP_LAST)
						proto_d = P_CRC_TX;
				end
				P_RM_DATA:
				begin
					crc_upd = 1'b1;
					addr_d = addr_q + 1'b1;
					idx_d = 3'h0;
					if (addr_q[4:0] == SP_LAST)
						proto_d = P_CRC_TX;
				end
				P_CP_ES:
				begin
					proto_d = P_WAIT;
					if (auth_q && sh_q == es_byte)
					begin
						aa_d = 1'b1;
						copy_d = 1'b1;
					end
				end
				P_CRC_TX:
				begin
					idx_d = idx_q + 1'b1;
					if (idx_q != 3'h0)
					begin
						proto_d = P_WAIT;
						if (kind_q == K_RM)
						begin
							crc_clr = 1'b1;
							proto_d = P_RM_DATA;
						end
					end
				end
				default:
				begin
					proto_d = P_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			proto_q <= P_WAIT;
			kind_q <= K_WS;
			idx_q <= 3'h0;
			off_q <= 5'h00;
			end_q <= 5'h00;
			ta_q <= 16'h0000;
			addr_q <= 16'h0000;
			aa_q <= 1'b0;
			pf_q <= 1'b0;
			auth_q <= 1'b0;
			copy_q <= 1'b0;
		end
		else if (ce_i)
		begin
			proto_q <= proto_d;
			kind_q <= kind_d;
			idx_q <= idx_d;
			off_q <= off_d;
			end_q <= end_d;
			ta_q <= ta_d;
			addr_q <= addr_d;
			aa_q <= aa_d;
			pf_q <= pf_d;
			auth_q <= auth_d;
			copy_q <= copy_d;
		end
	end

	// Scratchpad storage; no reset so it maps onto plain RAM
	always_ff @(posedge clock_i)
	begin
		if (ce_i)
		begin
			if (sp_we)
				scratch[off_q] <= sh_q;
			rd_q <= scratch[scratch_raddr_i];
		end
	end

	assign dq_o = 1'b0;
	assign dq_oe_n_o = !drive_q;
	assign fast_speed_flag_o = fast_q;
	assign mem_addr_o = addr_q;
	assign copy_strobe_o = copy_q;
	assign copy_addr_o = ta_q;
	assign copy_end_o = end_q;
	assign scratch_rdata_o = rd_q;

	// Checks on the line timing and byte sequencing
	sequence s_rise_seen;
		ce_i && link_q == L_RST_RISE && dq_i;
	endsequence
	sequence s_pdh_over;
		ce_i && link_q == L_PD_HIGH && cnt_q == t_pdh;
	endsequence

	a_presence_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		s_rise_seen |=> link_q == L_PD_HIGH && cnt_q == '0 && dq_oe_n_o) else $error("presence delay not started");
	a_presence_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		s_pdh_over |=> link_q == L_PD_LOW && !dq_oe_n_o) else $error("presence pulse not driven");
	a_ready_slot: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ce_i && link_q == L_PD_LOW && cnt_q == t_pdl) |=> link_q == L_IDLE && proto_q == P_ROM_CMD && dq_oe_n_o)
		else $error("not ready after presence");
	a_slot_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ce_i && link_q == L_IDLE && !dq_i) |=> link_q == L_SLOT && cnt_q == '0) else $error("slot timer not started");
	a_sample_bit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ce_i && link_q == L_SLOT && cnt_q == t_sls) |=> bit_q == $past(dq_i) && sh_q[7] == $past(dq_i))
		else $error("write bit not sampled");
	a_one_bit_slot: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ce_i && link_q == L_SLOT ##1 link_q == L_IDLE) |-> bit_cnt_q == 3'($past(bit_cnt_q) + 1'b1))
		else $error("slot did not carry one bit");
	a_read_zero_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(link_q == L_SLOT && tx_zero_q && cnt_q < t_spd) |-> !dq_oe_n_o) else $error("read zero released early");
	a_read_one_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(link_q == L_SLOT && !tx_zero_q) |-> dq_oe_n_o) else $error("read one pulled low");
	a_crc_inverted: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ce_i && link_q == L_IDLE && !dq_i && proto_q == P_CRC_TX && bit_cnt_q == 3'h0 && idx_q == 3'h0)
		|=> tx_byte_q == ~$past(crc[7:0])) else $error("CRC not sent inverted");
	a_ws_crc_end: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		($past(proto_q) == P_WS_DATA && proto_q == P_CRC_TX) |-> $past(off_q) == SP_LAST)
		else $error("write CRC before last offset");
	a_id_crc_top: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ce_i && link_q == L_IDLE && !dq_i && proto_q == P_ROM_TX && bit_cnt_q == 3'h0 && idx_q == ID_LAST_BYTE)
		|=> tx_byte_q == id_crc) else $error("identity CRC byte wrong");

endmodule // swire_slave

// [design/swire_pkg.sv]
// Purpose: Shared constants for the single-wire slave: commands, timing, field layout
// Assumes: 250 MHz clock; all times held in ns and turned into cycle counts here
// Notes: Counts above 4096 cycles, the standard-speed ones and the fast-speed reset, become top-level parameters
package swire_pkg;

	localparam int CLK_NS = 4;
	localparam int CNT_W = 18;

	// Line timing in ns; standard and fast speed
	localparam int STD_RST_LOW_NS = 480000; // reset_low_time, standard
	localparam int OD_RST_LOW_NS = 62000; // reset_low_time, fast speed
	localparam int STD_PDH_NS = 30000; // presence_high_delay
	localparam int STD_PDL_NS = 120000; // presence_low_time
	localparam int STD_SLS_NS = 30000; // slave_sample_window sample point
	localparam int STD_SPD_NS = 45000; // slave_pulldown_time
	localparam int OD_PDH_NS = 3000;
	localparam int OD_PDL_NS = 12000;
	localparam int OD_SLS_NS = 3000;
	localparam int OD_SPD_NS = 4000;

	// Least time: round up, never below one cycle
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Longest time: round down, never below one cycle
	function automatic int cyc_dn(input int ns);
		int c;
		c = ns / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int OD_PDH_CYC = cyc_dn(OD_PDH_NS);
	localparam int OD_PDL_CYC = cyc_up(OD_PDL_NS);
	localparam int OD_SLS_CYC = cyc_dn(OD_SLS_NS);
	localparam int OD_SPD_CYC = cyc_up(OD_SPD_NS);

	// Identity-level commands
	localparam logic [7:0] CMD_READ_ID = 8'h33;
	localparam logic [7:0] CMD_SKIP_ID = 8'hcc;
	localparam logic [7:0] CMD_FAST_SKIP = 8'h3c;
	// Memory commands
	localparam logic [7:0] CMD_WRITE_SP = 8'h0f;
	localparam logic [7:0] CMD_READ_SP = 8'haa;
	localparam logic [7:0] CMD_COPY_SP = 8'h55;
	localparam logic [7:0] CMD_READ_MEM_CRC = 8'ha5;

	// Scratchpad and status byte layout
	localparam int SP_DEPTH = 32;
	localparam logic [4:0] SP_LAST = 5'h1f;
	localparam int ES_AA_BIT = 7;
	localparam int ES_PF_BIT = 5;
	localparam logic [2:0] ID_LAST_BYTE = 3'h7;
	localparam logic [2:0] HDR_LAST = 3'h2;

	// CRC polynomials, reflected for lsb-first shifting
	localparam logic [7:0] CRC8_POLY_R = 8'h8c;
	localparam logic [15:0] CRC16_POLY_R = 16'ha001;

	// Identity contents; values are arbitrary
	localparam logic [7:0] ID_FAMILY = 8'h5a;
	localparam logic [47:0] ID_SERIAL = 48'h0123_4567_89ab;

endpackage

// [design/crc16_gen.sv]
// Purpose: 16-bit CRC accumulator, x^16+x^15+x^2+1, bytes shifted lsb first
// Assumes: clear and update may come together; clear then folds the byte in
// Notes: Output is the true value; the caller inverts before sending
`timescale 1ns/10ps
module crc16_gen
	import swire_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic clear_i,
	input wire logic upd_i,
	input wire logic [7:0] data_i,
	output logic [15:0] crc_o
);

	logic [15:0] crc_q;
	logic [15:0] crc_d;

	// One byte through the reflected generator, lsb first
	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC16_POLY_R) : (r >> 1);
		end
		return r;
	endfunction

	// Clear starts from zero so a command byte lands on a fresh generator
	always_comb
	begin
		crc_d = clear_i ? 16'h0000 : crc_q;
		if (upd_i)
		begin
			crc_d = crc16_byte(crc_d, data_i);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			crc_q <= 16'h0000;
		else if (ce_i)
			crc_q <= crc_d;
	end

	assign crc_o = crc_q;

endmodule // crc16_gen

// [design/crc8_rom.sv]
// Purpose: 8-bit identity CRC, x^8+x^5+x^4+1, over the low 56 identity bits
// Assumes: Input is constant; result folds to a constant in synthesis
// Notes: Bits enter lsb first, the order in which they leave on the line
`timescale 1ns/10ps
module crc8_rom
	import swire_pkg::*;
(
	input wire logic [55:0] data_i,
	output logic [7:0] crc_o
);

	// Reflected shift register walk
	always_comb
	begin
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 56; i++)
		begin
			r = (r[0] ^ data_i[i]) ? ((r >> 1) ^ CRC8_POLY_R) : (r >> 1);
		end
		crc_o = r;
	end

endmodule // crc8_rom

// [sim/swire_master.sv]
// Purpose: Bus master model for the single-wire slave: line reset, write and read slots
// Assumes: Tasks are entered just after a rising clock edge
// Notes: Only pulls low or releases; the bench forms the wired-AND line with pull-up
`timescale 1ns/10ps
module swire_master
(
	input wire logic clock_i,
	input wire logic line_i,
	output logic drv_n_o
);
	// Released at power-up so the pull-up holds the line high
	initial drv_n_o = 1'b1;

	// Long low, release, then watch presence over the whole recovery interval
	task automatic line_reset(input int low_cyc, output int dly, output int len);
		int i;
		drv_n_o <= 1'b0;
		repeat (low_cyc) @(posedge clock_i);
		drv_n_o <= 1'b1;
		dly = 0;
		len = 0;
		for (i = 0; i < 200; i++) // Covers delay, pulse and recovery
		begin
			// Mid-cycle sample, clear of the edge that launches the enable
			@(negedge clock_i);
			if (line_i === 1'b0)
				len++;
			else if (len == 0)
				dly++;
		end
		@(posedge clock_i); // Back on the rising edge for the next drive
	endtask

	// One bit per slot; short pulse for one or read, long pulse for zero
	task automatic slot(input logic wb, output logic rb);
		int i;
		drv_n_o <= 1'b0;
		rb = 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clock_i);
			if (i == 2 && wb)
				drv_n_o <= 1'b1; // High well before the sample point
			if (i == 22)
				drv_n_o <= 1'b1; // Past the latest sample point
			if (i == 8)
				rb = line_i; // Early, before the shortest pull-down ends
		end
		// Forty cycles leave pull-down end plus recovery before the next fall
	endtask

	// Bytes go out and come in lsb first
	task automatic wr_byte(input logic [7:0] b);
		int i;
		logic r;
		for (i = 0; i < 8; i++)
			slot(b[i], r);
	endtask

	task automatic rd_byte(output logic [7:0] b);
		int i;
		for (i = 0; i < 8; i++)
			slot(1'b1, b[i]);
	endtask
endmodule // swire_master

// [sim/swire_slave_tb.sv]
// Purpose: Self-checking bench for the single-wire slave
// Assumes: Shortened standard counts; fast-speed slot timing is not exercised
// Notes: Expected bytes and CRCs come from the bench's own model
`timescale 1ns/10ps
module swire_slave_tb
	import swire_pkg::*;
;
	localparam int RST = 400;
	localparam int PDH = 20;
	localparam int PDL = 60;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] mem_rdata_i = 8'h00;
	logic [4:0] scratch_raddr_i = 5'h00;
	logic dq_o, dq_oe_n_o, fast_speed_flag_o, copy_strobe_o, drv_n, line;
	logic [15:0] mem_addr_o, copy_addr_o, crc, ta;
	logic [4:0] copy_end_o;
	logic [7:0] scratch_rdata_o;
	logic [7:0] sp [32];
	logic [55:0] rom = {ID_SERIAL, ID_FAMILY};
	integer seed = 32'hda23;
	int n_fail = 0;
	int num_checks = 0;
	int n_strobe = 0;
	int off;

	// 250 MHz clock
	always #2 clock_i = ~clock_i;
	// Pull-up; any low enable pulls the line down
	assign line = drv_n & dq_oe_n_o;

	swire_slave #(.STD_RST_CYC(RST), .OD_RST_CYC(200), .STD_PDH_CYC(PDH), .STD_PDL_CYC(PDL),
		.STD_SLS_CYC(15), .STD_SPD_CYC(25)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.dq_i(line), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .fast_speed_flag_o(fast_speed_flag_o),
		.mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i), .copy_strobe_o(copy_strobe_o),
		.copy_addr_o(copy_addr_o), .copy_end_o(copy_end_o), .scratch_raddr_i(scratch_raddr_i),
		.scratch_rdata_o(scratch_rdata_o));

	swire_master bus_master (.clock_i(clock_i), .line_i(line), .drv_n_o(drv_n));

	function automatic logic [7:0] mem_val(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5c;
	endfunction

	// Memory answers a cycle after the address; commit pulses are counted
	always @(posedge clock_i)
	begin
		mem_rdata_i <= mem_val(mem_addr_o);
		if (copy_strobe_o === 1'b1)
			n_strobe <= n_strobe + 1;
	end

	// Reflected polynomials, lsb first, as bits travel on the line
	function automatic logic [15:0] crc16_add(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		return c;
	endfunction

	function automatic logic [7:0] crc8_of(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
		return c;
	endfunction

	task automatic fail(input string msg);
		n_fail++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
			fail($sformatf("byte %h, expected %h", got, exp));
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
			fail($sformatf("flag %b, expected %b", got, exp));
	endtask

	task automatic cmp_range(input int got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi)
			fail($sformatf("count %0d outside %0d..%0d", got, lo, hi));
	endtask

	task automatic test_done(input string name);
		$display("test %s done", name);
	endtask

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Reset, presence timing from the release, then the identity command
	task automatic init(input logic [7:0] cmd);
		int d, l;
		bus_master.line_reset(RST + 50, d, l);
		cmp_range(d, PDH, PDH + 3);
		cmp_range(l, PDL, PDL + 2);
		bus_master.wr_byte(cmd);
		crc = 16'h0000;
	endtask

	task automatic send(input logic [7:0] b);
		bus_master.wr_byte(b);
		crc = crc16_add(crc, b);
	endtask

	task automatic recv(input logic [7:0] exp);
		logic [7:0] g;
		bus_master.rd_byte(g);
		cmp_byte(g, exp);
		crc = crc16_add(crc, exp);
	endtask

	// Inverted CRC, low byte first; the generator then starts clean
	task automatic recv_crc();
		logic [15:0] e;
		logic [7:0] g;
		e = ~crc;
		bus_master.rd_byte(g);
		cmp_byte(g, e[7:0]);
		bus_master.rd_byte(g);
		cmp_byte(g, e[15:8]);
		crc = 16'h0000;
	endtask

	task automatic sp_head(input logic [7:0] cmd);
		init(8'hcc);
		send(cmd);
		send(ta[7:0]);
		send(ta[15:8]);
	endtask

	task automatic rd_sp(input logic [7:0] es);
		init(8'hcc);
		send(8'haa);
		recv(ta[7:0]);
		recv(ta[15:8]);
		recv(es);
		for (int o = off; o < 32; o++)
			recv(sp[o]);
		recv_crc();
	endtask

	// Main sequence; each test leaves the line idle
	initial
	begin
		int o, n;
		logic [15:0] a;
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		init(CMD_READ_ID);
		for (o = 0; o < 7; o++)
			recv(rom[8*o +: 8]);
		recv(crc8_of(rom));
		test_done("identity");
		off = 24 + ($random(seed) & 7);
		ta = {11'($random(seed)), 5'(off)};
		sp_head(8'h0f);
		for (o = off; o < 32; o++)
		begin
			sp[o] = 8'($random(seed));
			send(sp[o]);
		end
		recv_crc();
		for (o = off; o < 32; o++)
		begin
			scratch_raddr_i <= 5'(o);
			repeat (2) @(posedge clock_i);
			cmp_byte(scratch_rdata_o, sp[o]);
		end
		test_done("scratch write");
		rd_sp(8'h1f);
		test_done("scratch read");
		// A wrong status echo must not commit; the right one commits once
		for (o = 0; o < 2; o++)
		begin
			sp_head(8'h55);
			send(8'h1e + 8'(o));
			repeat (4) @(posedge clock_i);
			cmp_byte(8'(n_strobe), 8'(o));
		end
		cmp_byte(copy_addr_o[7:0], ta[7:0]);
		cmp_byte(copy_addr_o[15:8], ta[15:8]);
		cmp_byte({3'h0, copy_end_o}, 8'h1f);
		rd_sp(8'h9f);
		test_done("commit");
		ta = {11'($random(seed)), 5'h1e};
		sp_head(CMD_READ_MEM_CRC);
		a = ta;
		n = 0;
		while (n < 2)
		begin
			recv(mem_val(a));
			if (a[4:0] == 5'h1f)
			begin
				recv_crc();
				n++;
			end
			a++;
		end
		test_done("memory read");
		init(CMD_FAST_SKIP);
		repeat (2) @(posedge clock_i);
		cmp_bit(fast_speed_flag_o, 1'b1);
		bus_master.line_reset(RST + 50, o, n);
		cmp_bit(fast_speed_flag_o, 1'b0);
		cmp_bit(dq_o, 1'b0);
		test_done("speed");
		complete_run();
	end

	// Tests need about 40k cycles; over twice that means a hang
	initial
	begin
		repeat (90000) @(posedge clock_i);
		fail("watchdog expired");
		complete_run();
	end
endmodule // swire_slave_tb
